// ### src/dctd_pkg.sv
// Constants shared by the level-code trim datapath: register byte offsets,
// address field layout, reset values and word widths.
// Assumes a 32-bit APB slave with one aligned word per register.
package dctd_pkg;

    // Word widths and the comparator set count
    localparam int LEVEL_W      = 16;
    localparam int FORCE_W      = 18;
    localparam int CMP_SETS     = 7;
    localparam int RANGE_SEL_W  = 3;

    // Byte offsets of the trim sets; each set is word, gain, offset
    localparam logic [7:0] OFS_FORCE_WORD   = 8'h00;
    localparam logic [7:0] OFS_FORCE_GAIN   = 8'h04;
    localparam logic [7:0] OFS_FORCE_OFFSET = 8'h08;
    localparam logic [7:0] OFS_CMP_BASE     = 8'h10;
    localparam logic [7:0] OFS_CMP_STRIDE   = 8'h10;
    localparam logic [7:0] OFS_CLAMP_WORD   = 8'h80;
    localparam logic [7:0] OFS_CLAMP_GAIN   = 8'h84;
    localparam logic [7:0] OFS_CLAMP_OFFSET = 8'h88;

    // Byte offsets of the single codes, control and readback
    localparam logic [7:0] OFS_OFFSET_LEVEL = 8'h90;
    localparam logic [7:0] OFS_OPEN_SENSE   = 8'h94;
    localparam logic [7:0] OFS_GROUND_SENSE = 8'h98;
    localparam logic [7:0] OFS_CONTROL      = 8'h9c;
    localparam logic [7:0] OFS_STAT_FORCE   = 8'ha0;
    localparam logic [7:0] OFS_STAT_CMP     = 8'ha4;
    localparam logic [7:0] OFS_STAT_CLAMP   = 8'ha8;

    // Field offsets inside a trim set
    localparam logic [7:0] FLD_WORD   = 8'h00;
    localparam logic [7:0] FLD_GAIN   = 8'h04;
    localparam logic [7:0] FLD_OFFSET = 8'h08;

    // Control register field positions
    localparam int CTRL_GAIN_BIT  = 0;
    localparam int CTRL_RANGE_LSB = 4;

    // Values after reset
    localparam logic [15:0] RST_WORD         = 16'h0000;
    localparam logic [15:0] RST_GAIN         = 16'hffff;
    localparam logic [15:0] RST_OFFSET       = 16'h8000;
    localparam logic [15:0] RST_OFFSET_LEVEL = 16'h8000;
    localparam logic [15:0] RST_OPEN_SENSE   = 16'h0000;
    localparam logic [15:0] RST_GROUND_SENSE = 16'h0000;
    localparam logic        RST_GAIN_TWENTY  = 1'b1;
    localparam logic [2:0]  RST_RANGE_SEL    = 3'h0;

endpackage

// ### src/dctd_correct.sv
// Gain and offset correction of one requested level word.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps

module dctd_correct #(
    parameter int OUT_W = 16
) (
    input  wire logic [15:0]      requested_level_word,
    input  wire logic [15:0]      gain_code,
    input  wire logic [15:0]      offset_code,
    output logic      [OUT_W-1:0] corrected_level_word
);

    localparam int EXTRA = OUT_W - 16;
    localparam int SW    = OUT_W + 3;

    logic        [16:0]   gain_plus_one;
    logic        [32:0]   product;
    logic        [OUT_W:0] scaled;
    logic        [SW-1:0] offset_u;
    logic        [SW-1:0] half_u;
    logic        [SW-1:0] limit_u;
    logic signed [SW-1:0] sum_s;

    // Scale by gain plus one over 2^16, keeping EXTRA fraction bits
    assign gain_plus_one = {1'b0, gain_code} + 17'h00001;
    assign product = {17'h00000, requested_level_word}
                   * {16'h0000, gain_plus_one};
    assign scaled  = product[32:16-EXTRA];

    // Offset term is the code less half scale, at output resolution
    assign offset_u = SW'(offset_code) << EXTRA;
    assign half_u   = SW'(1) << (15 + EXTRA);
    assign limit_u  = (SW'(1) << OUT_W) - SW'(1);
    assign sum_s    = signed'(SW'(scaled)) + signed'(offset_u - half_u);

    // Saturate into zero through all ones
    always_comb begin
        if (sum_s < 0) begin
            corrected_level_word = '0;
        end else if (unsigned'(sum_s) > limit_u) begin
            corrected_level_word = '1;
        end else begin
            corrected_level_word = sum_s[OUT_W-1:0];
        end
    end

endmodule

// ### src/dctd_top.sv
// Level-code trim datapath: trim register file on APB and the corrected
// codes handed to the force, comparator and clamp level converters.
// Assumes an APB master on pclk; zero wait states, pready from a flop.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps

// How it works
// - Each 16-bit corrected code is word times gain plus one over 2^16 plus offset less 2^15; the 18-bit force code is four times that.
// - Every gain trim resets to all ones so an untrimmed word passes unscaled.
// - Every offset trim resets to half scale so the offset term starts at zero.
// - The requested word written by software is 16 bits and is what gets scaled.
// - The force level has exactly one set of word, gain and offset registers.
// - The comparator level has seven sets, one per current range.
// - The clamp level has one shared 16-bit set for all ranges.
// - A 16-bit offset level code is held and driven out to shift the levels.
// - The open-sense level leaves unaffected by the offset level code.
// - A 16-bit ground-sense threshold code is held and driven out.
// - The measure current gain is selectable between ten and twenty.
// - The force path keeps 18 bits so reduced spans keep full resolution.
module dctd_top
    import dctd_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic      [FORCE_W-1:0] force_level,
    output logic      [LEVEL_W-1:0] comparator_level,
    output logic      [LEVEL_W-1:0] clamp_level,
    output logic      [LEVEL_W-1:0] offset_level_code,
    output logic      [LEVEL_W-1:0] open_sense_level,
    output logic      [LEVEL_W-1:0] ground_sense_level,
    output logic                   measure_gain_twenty
);

    // Trim storage
    logic [15:0] force_word;
    logic [15:0] force_gain;
    logic [15:0] force_offset;
    logic [15:0] cmp_word   [CMP_SETS];
    logic [15:0] cmp_gain   [CMP_SETS];
    logic [15:0] cmp_offset [CMP_SETS];
    logic [15:0] clamp_word;
    logic [15:0] clamp_gain;
    logic [15:0] clamp_offset;
    logic [15:0] offset_level;
    logic [15:0] open_sense;
    logic [15:0] ground_sense;
    logic        gain_twenty;
    logic [2:0]  range_sel;

    // Bus decode
    logic [7:0]  addr;
    logic        upper_zero;
    logic        setup;
    logic        wr_strobe;
    logic [15:0] wdata16;
    logic [3:0]  cmp_slot;
    logic [7:0]  cmp_field;
    logic        in_cmp;
    logic [2:0]  cmp_index;
    logic        hit_cmp_field;
    logic        hit_fixed;
    logic        hit_ro;
    logic        hit_any;

    // Datapath
    logic [2:0]         active_range;
    logic [FORCE_W-1:0] force_corr;
    logic [LEVEL_W-1:0] cmp_corr;
    logic [LEVEL_W-1:0] clamp_corr;
    logic [31:0]        rd_value;
    logic [31:0]        cmp_rd;
    logic [31:0]        fixed_rd;

    // Address split; the comparator sets occupy cmp_slot 0 to 6
    assign addr       = paddr[7:0];
    assign upper_zero = (paddr[ADDR_W-1:8] == '0);
    assign setup      = psel & ~penable;
    assign wr_strobe  = psel & penable & pready & pwrite & ~pslverr;
    assign wdata16    = pwdata[15:0];
    assign cmp_slot   = 4'((addr - OFS_CMP_BASE) >> 4);
    assign cmp_field  = (addr - OFS_CMP_BASE) & (OFS_CMP_STRIDE - 8'h01);
    assign in_cmp     = (addr >= OFS_CMP_BASE) && (addr < OFS_CLAMP_WORD);
    assign cmp_index  = cmp_slot[2:0];
    assign hit_cmp_field = in_cmp && (cmp_field == FLD_WORD ||
                           cmp_field == FLD_GAIN || cmp_field == FLD_OFFSET);
    assign hit_fixed  = (addr == OFS_FORCE_WORD)   ||
                        (addr == OFS_FORCE_GAIN)   ||
                        (addr == OFS_FORCE_OFFSET) ||
                        (addr == OFS_CLAMP_WORD)   ||
                        (addr == OFS_CLAMP_GAIN)   ||
                        (addr == OFS_CLAMP_OFFSET) ||
                        (addr == OFS_OFFSET_LEVEL) ||
                        (addr == OFS_OPEN_SENSE)   ||
                        (addr == OFS_GROUND_SENSE) ||
                        (addr == OFS_CONTROL);
    assign hit_ro     = (addr == OFS_STAT_FORCE) ||
                        (addr == OFS_STAT_CMP)   ||
                        (addr == OFS_STAT_CLAMP);
    assign hit_any    = upper_zero && (addr[1:0] == 2'b00) &&
                        (hit_cmp_field || hit_fixed || hit_ro);

    // Out-of-range selects fall back to the first current range
    assign active_range = (range_sel < RANGE_SEL_W'(CMP_SETS)) ?
                          range_sel : 3'h0;

    // Correction units; the force path carries two extra bits
    dctd_correct #(.OUT_W(FORCE_W)) u_force (
        .requested_level_word (force_word),
        .gain_code            (force_gain),
        .offset_code          (force_offset),
        .corrected_level_word (force_corr)
    );

    dctd_correct #(.OUT_W(LEVEL_W)) u_cmp (
        .requested_level_word (cmp_word[active_range]),
        .gain_code            (cmp_gain[active_range]),
        .offset_code          (cmp_offset[active_range]),
        .corrected_level_word (cmp_corr)
    );

    dctd_correct #(.OUT_W(LEVEL_W)) u_clamp (
        .requested_level_word (clamp_word),
        .gain_code            (clamp_gain),
        .offset_code          (clamp_offset),
        .corrected_level_word (clamp_corr)
    );

    // Read selection for the comparator sets
    assign cmp_rd = (cmp_field == FLD_WORD) ? {16'h0000, cmp_word[cmp_index]} :
                    (cmp_field == FLD_GAIN) ? {16'h0000, cmp_gain[cmp_index]} :
                    {16'h0000, cmp_offset[cmp_index]};

    // Read selection for the single registers and readback
    always_comb begin
        fixed_rd = 32'h00000000;
        unique case (addr)
            OFS_FORCE_WORD:   fixed_rd = {16'h0000, force_word};
            OFS_FORCE_GAIN:   fixed_rd = {16'h0000, force_gain};
            OFS_FORCE_OFFSET: fixed_rd = {16'h0000, force_offset};
            OFS_CLAMP_WORD:   fixed_rd = {16'h0000, clamp_word};
            OFS_CLAMP_GAIN:   fixed_rd = {16'h0000, clamp_gain};
            OFS_CLAMP_OFFSET: fixed_rd = {16'h0000, clamp_offset};
            OFS_OFFSET_LEVEL: fixed_rd = {16'h0000, offset_level};
            OFS_OPEN_SENSE:   fixed_rd = {16'h0000, open_sense};
            OFS_GROUND_SENSE: fixed_rd = {16'h0000, ground_sense};
            OFS_CONTROL: begin
                fixed_rd[CTRL_GAIN_BIT] = gain_twenty;
                fixed_rd[CTRL_RANGE_LSB +: 3] = range_sel;
            end
            OFS_STAT_FORCE:   fixed_rd = {14'h0000, force_level};
            OFS_STAT_CMP:     fixed_rd = {16'h0000, comparator_level};
            OFS_STAT_CLAMP:   fixed_rd = {16'h0000, clamp_level};
            default:          fixed_rd = 32'h00000000;
        endcase
    end

    assign rd_value = !hit_any      ? 32'h00000000 :
                      hit_cmp_field ? cmp_rd : fixed_rd;

    // APB answer: ready in the access phase, error on unmapped or on writes to read-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & (~hit_any | (pwrite & hit_ro));
            prdata  <= (setup & ~pwrite) ? rd_value : 32'h00000000;
        end
    end

    // Force trim set, a single one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_word   <= RST_WORD;
            force_gain   <= RST_GAIN;
            force_offset <= RST_OFFSET;
        end else if (wr_strobe) begin
            if (addr == OFS_FORCE_WORD)   force_word   <= wdata16;
            if (addr == OFS_FORCE_GAIN)   force_gain   <= wdata16;
            if (addr == OFS_FORCE_OFFSET) force_offset <= wdata16;
        end
    end

    // Comparator trim sets, one per current range
    for (genvar g = 0; g < CMP_SETS; g++) begin : g_cmp
        logic sel;
        assign sel = wr_strobe & hit_cmp_field & (cmp_index == 3'(g));
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cmp_word[g]   <= RST_WORD;
                cmp_gain[g]   <= RST_GAIN;
                cmp_offset[g] <= RST_OFFSET;
            end else if (sel) begin
                if (cmp_field == FLD_WORD)   cmp_word[g]   <= wdata16;
                if (cmp_field == FLD_GAIN)   cmp_gain[g]   <= wdata16;
                if (cmp_field == FLD_OFFSET) cmp_offset[g] <= wdata16;
            end
        end
    end

    // Clamp trim set, shared across all ranges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clamp_word   <= RST_WORD;
            clamp_gain   <= RST_GAIN;
            clamp_offset <= RST_OFFSET;
        end else if (wr_strobe) begin
            if (addr == OFS_CLAMP_WORD)   clamp_word   <= wdata16;
            if (addr == OFS_CLAMP_GAIN)   clamp_gain   <= wdata16;
            if (addr == OFS_CLAMP_OFFSET) clamp_offset <= wdata16;
        end
    end

    // Single codes and control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            offset_level <= RST_OFFSET_LEVEL;
            open_sense   <= RST_OPEN_SENSE;
            ground_sense <= RST_GROUND_SENSE;
            gain_twenty  <= RST_GAIN_TWENTY;
            range_sel    <= RST_RANGE_SEL;
        end else if (wr_strobe) begin
            if (addr == OFS_OFFSET_LEVEL) offset_level <= wdata16;
            if (addr == OFS_OPEN_SENSE)   open_sense   <= wdata16;
            if (addr == OFS_GROUND_SENSE) ground_sense <= wdata16;
            if (addr == OFS_CONTROL) begin
                gain_twenty <= pwdata[CTRL_GAIN_BIT];
                range_sel   <= pwdata[CTRL_RANGE_LSB +: 3];
            end
        end
    end

    // Registered level outputs; open sense bypasses the offset level code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_level         <= '0;
            comparator_level    <= '0;
            clamp_level         <= '0;
            offset_level_code   <= RST_OFFSET_LEVEL;
            open_sense_level    <= RST_OPEN_SENSE;
            ground_sense_level  <= RST_GROUND_SENSE;
            measure_gain_twenty <= RST_GAIN_TWENTY;
        end else begin
            force_level         <= force_corr;
            comparator_level    <= cmp_corr;
            clamp_level         <= clamp_corr;
            offset_level_code   <= offset_level;
            open_sense_level    <= open_sense;
            ground_sense_level  <= ground_sense;
            measure_gain_twenty <= gain_twenty;
        end
    end

endmodule

// ### verif/dctd_top_chk.sv
// Concurrent checks on the ports of the level-code trim datapath.
// Assumes binding to dctd_top; sees only its ports, one pclk domain.
`timescale 1ns/1ps

module dctd_top_chk
    import dctd_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [ADDR_W-1:0]   paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [FORCE_W-1:0]  force_level,
    input wire logic [LEVEL_W-1:0]  comparator_level,
    input wire logic [LEVEL_W-1:0]  clamp_level,
    input wire logic [LEVEL_W-1:0]  offset_level_code,
    input wire logic [LEVEL_W-1:0]  open_sense_level,
    input wire logic [LEVEL_W-1:0]  ground_sense_level,
    input wire logic                measure_gain_twenty
);
    // Setup phase decode and write targets
    wire setup  = psel && !penable;
    wire wr_set = setup && pwrite;
    wire wr_ofs = wr_set && paddr == ADDR_W'(OFS_OFFSET_LEVEL);
    wire wr_gnd = wr_set && paddr == ADDR_W'(OFS_GROUND_SENSE);
    wire wr_ctl = wr_set && paddr == ADDR_W'(OFS_CONTROL);

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_READY_NEXT: assert property (setup |=> pready)
        else $error("pready missing after setup");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready held beyond one cycle");
    AST_IDLE_ZERO: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("bus outputs not idle");
    AST_UPPER_ERR: assert property (setup && paddr[ADDR_W-1:8] != '0
        |=> pslverr && prdata == 32'h0)
        else $error("upper address not refused");
    AST_RO_ERR: assert property (wr_set
        && paddr == ADDR_W'(OFS_STAT_FORCE) |=> pready && pslverr)
        else $error("readback write not refused");
    AST_OFS_LEVEL: assert property (wr_ofs |-> ##3
        offset_level_code == $past(pwdata[15:0], 3))
        else $error("offset level code not applied");
    AST_OPEN_KEEP: assert property (
        wr_ofs |=> $stable(open_sense_level) [*3])
        else $error("open sense moved with offset level");
    AST_GND_LEVEL: assert property (wr_gnd |-> ##3
        ground_sense_level == $past(pwdata[15:0], 3))
        else $error("ground sense code not applied");
    AST_GAIN_SEL: assert property (wr_ctl |-> ##3
        measure_gain_twenty == $past(pwdata[0], 3))
        else $error("measure gain not applied");
endmodule

bind dctd_top dctd_top_chk #(.ADDR_W(ADDR_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .force_level(force_level),
    .comparator_level(comparator_level), .clamp_level(clamp_level),
    .offset_level_code(offset_level_code),
    .open_sense_level(open_sense_level),
    .ground_sense_level(ground_sense_level),
    .measure_gain_twenty(measure_gain_twenty)
);

// ### verif/dctd_host.sv
// APB host controller model that loads level and trim codes.
// Assumes its tasks are called right after a rising pclk edge.
`timescale 1ns/1ps

module dctd_host (
    input  wire logic        pclk,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    // Bus idle at time zero
    initial begin
        {psel, penable, pwrite} = 3'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
    end

    // One APB transfer; holds the request until pready is seen at an edge
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // Only the bench watchdog ends a wait that never answers
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        // Answer is taken at the edge where pready is sampled high
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines carry garbage, never the last value
        paddr <= ~a;
        pwdata <= ~d;
    endtask

    // Trim one set from measured error counts in LSBs
    task automatic cal(input logic [11:0] base, input int zerr,
                       input int gerr);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, base + 12'h8, 32'(32768 + zerr), q, e);
        xfer(1'b1, base + 12'h4, 32'(65535 - gerr), q, e);
    endtask
endmodule

// ### verif/test_dac_code_trim_datapath.sv
// Self-checking bench for the level-code trim datapath.
// Assumes dctd_top, its bound checker and the dctd_host model.
`timescale 1ns/1ps

module test_dac_code_trim_datapath;
    import dctd_pkg::*;

    logic                pclk;
    logic                presetn;
    logic                psel, penable, pwrite, pready, pslverr;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata, q;
    logic                e;
    logic [FORCE_W-1:0]  force_level;
    logic [LEVEL_W-1:0]  cmp_lv, clamp_lv, ofs_lv, open_lv, gnd_lv;
    logic                gain20;
    int                  n_mismatch, num_checks;
    logic [15:0]         cw[4], cg[4], co[4];

    dctd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .force_level(force_level), .comparator_level(cmp_lv),
        .clamp_level(clamp_lv), .offset_level_code(ofs_lv),
        .open_sense_level(open_lv), .ground_sense_level(gnd_lv),
        .measure_gain_twenty(gain20));
    dctd_host u_host (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // Clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        #200000;
        n_mismatch++;
        conclude();
    end

    task automatic chk(input string nm, input logic [31:0] s, x);
        num_checks++;
        if (s !== x) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        u_host.xfer(1'b1, a, d, q, e);
        chk("write error", 32'(e), 32'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        u_host.xfer(1'b0, a, 32'h0, q, e);
        chk("read data", q, x);
    endtask
    task automatic settle();
        repeat (2) @(posedge pclk);
        #1;
    endtask
    // Expected corrected codes, 16 and 18 bit, with saturation
    function automatic logic [31:0] e16(logic [15:0] w, g, o);
        longint v;
        v = ((longint'(w) * (longint'(g) + 1)) >> 16) + longint'(o) - 32768;
        v = v < 0 ? 0 : (v > 65535 ? 65535 : v);
        return 32'(v);
    endfunction
    function automatic logic [31:0] e18(logic [15:0] w, g, o);
        longint v;
        v = ((longint'(w) * (longint'(g) + 1)) >> 14)
            + (longint'(o) - 32768) * 4;
        v = v < 0 ? 0 : (v > 262143 ? 262143 : v);
        return 32'(v);
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        presetn = 1'b0;
        cw = '{16'hffff, 16'h1234, 16'hffff, 16'h0010};
        cg = '{16'hffff, 16'h4000, 16'hffff, 16'hffff};
        co = '{16'h8000, 16'h8000, 16'hffff, 16'h0000};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        chk("force reset", 32'(force_level), 32'h0);
        chk("gain20 reset", 32'(gain20), 32'h1);
        rd(12'h004, 32'hffff);
        rd(12'h008, 32'h8000);
        rd(12'h084, 32'hffff);
        rd(12'h088, 32'h8000);
        for (int k = 0; k < CMP_SETS; k++) begin
            rd(12'(16 + 16 * k + 4), 32'hffff);
            rd(12'(16 + 16 * k + 8), 32'h8000);
        end
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            wr(12'h000, {16'h0, cw[i]});
            wr(12'h004, {16'h0, cg[i]});
            wr(12'h008, {16'h0, co[i]});
            wr(12'h080, {16'h0, cw[i]});
            wr(12'h084, {16'h0, cg[i]});
            wr(12'h088, {16'h0, co[i]});
            settle();
            chk("force", 32'(force_level), e18(cw[i], cg[i], co[i]));
            chk("clamp", 32'(clamp_lv), e16(cw[i], cg[i], co[i]));
            rd(12'h0a8, e16(cw[i], cg[i], co[i]));
        end
        $display("test correction done");
        for (int k = 0; k < CMP_SETS; k++) begin
            wr(12'(16 + 16 * k), 32'(16'h1000 * (k + 1)));
            wr(12'(16 + 16 * k + 8), 32'(16'h8000 + k));
        end
        for (int k = 0; k < 8; k++) begin
            wr(12'h09c, 32'((k << 4) | (k & 1)));
            settle();
            chk("cmp", 32'(cmp_lv), 32'(16'h1000 * (k % 7 + 1) + k % 7));
            chk("gain20", 32'(gain20), 32'(k & 1));
        end
        $display("test comparator sets done");
        wr(12'h094, 32'h0000abcd);
        wr(12'h098, 32'h00001357);
        wr(12'h090, 32'h00002468);
        settle();
        chk("offset code", 32'(ofs_lv), 32'h2468);
        chk("open sense", 32'(open_lv), 32'habcd);
        chk("ground sense", 32'(gnd_lv), 32'h1357);
        $display("test single codes done");
        u_host.xfer(1'b0, 12'h08c, 32'h0, q, e);
        chk("unmapped err", {q[30:0], e}, 32'h1);
        u_host.xfer(1'b1, 12'h0a0, 32'h1, q, e);
        chk("readonly err", 32'(e), 32'h1);
        u_host.xfer(1'b0, 12'h100, 32'h0, q, e);
        chk("upper err", {q[30:0], e}, 32'h1);
        $display("test refusals done");
        wr(12'h080, 32'h00008000);
        u_host.cal(12'h080, -641, 328);
        settle();
        chk("calibrated", 32'(clamp_lv), e16(16'h8000, 16'hfeb7, 16'h7d7f));
        rd(12'h084, 32'hfeb7);
        $display("test calibration done");
        conclude();
    end
endmodule
